/* File: anpx_pkg.sv */
// Shared constants for the partner next page and extended status register bank.
package anpx_pkg;

	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;

	////////////////////////////////////////////////////////////////////////
	localparam logic [4:0]  PARTNER_NP_OFFSET   = 5'h08;
	localparam logic [4:0]  EXT_STATUS_OFFSET   = 5'h0F;

	localparam logic [15:0] PARTNER_NP_RESET    = 16'h0000;
	localparam logic [15:0] EXT_STATUS_VALUE    = 16'hA000;
	localparam logic [15:0] UNMAPPED_READ_VALUE = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	localparam int unsigned MORE_PAGES_BIT      = 15;
	localparam int unsigned NP_RESERVED_BIT     = 14;
	localparam int unsigned MESSAGE_PAGE_BIT    = 13;
	localparam int unsigned SECOND_ACK_BIT      = 12;
	localparam int unsigned PAGE_TOGGLE_BIT     = 11;
	localparam int unsigned CODE_FIELD_MSB      = 10;

	// Bits that survive a page load in 1000BASE-X layout.
	localparam logic [15:0] FIBER_NP_KEEP_MASK  = 16'hBFFF;

endpackage

/* File: anpx_toggle_track.sv */
// Tracks the expected toggle bit across a next page exchange and flags mismatches.
module anpx_toggle_track (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        base_load,
	input  wire logic        base_toggle,
	input  wire logic        page_load,
	input  wire logic        page_toggle,
	output logic             expected_toggle,
	output logic             toggle_mismatch
);

	typedef struct packed {
		logic expect_q;
		logic mismatch_q;
	} anpx_trk_t;

	anpx_trk_t s_q;
	anpx_trk_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.mismatch_q = 1'b0;
		if (base_load) begin
			s_d.expect_q = ~base_toggle;
		end else if (page_load) begin
			s_d.mismatch_q = (page_toggle != s_q.expect_q);
			s_d.expect_q   = ~page_toggle;
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expected_toggle = s_q.expect_q;
	assign toggle_mismatch = s_q.mismatch_q;

endmodule

/* File: anpx_regs.sv */
// Read-only partner next page and extended status registers on the management read port.
module anpx_regs (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        sgmii_mode,
	input  wire logic        base_load,
	input  wire logic [15:0] base_word,
	input  wire logic        page_load,
	input  wire logic [15:0] page_word,
	input  wire logic        rd_en,
	input  wire logic [4:0]  rd_addr,
	output logic [15:0]      rd_data,
	output logic             rd_valid,
	output logic             rd_unmapped,
	output logic             expected_toggle,
	output logic             toggle_mismatch
);

	typedef struct packed {
		logic [15:0] np_q;
		logic [15:0] rd_data_q;
		logic        rd_valid_q;
		logic        rd_unmapped_q;
	} anpx_state_t;

	anpx_state_t s_q;
	anpx_state_t s_d;
	logic        trk_mismatch;

	////////////////////////////////////////////////////////////////////////
	// Builds the stored page word for the current layout.
	function automatic logic [15:0] anpx_page_store(input logic sgmii, input logic [15:0] w);
		logic [15:0] r;
		r = w;
		if (!sgmii) begin
			r = w & anpx_pkg::FIBER_NP_KEEP_MASK;
		end
		return r;
	endfunction

	always_comb begin
		s_d = s_q;
		s_d.rd_valid_q = 1'b0;
		if (page_load) begin
			s_d.np_q = anpx_page_store(sgmii_mode, page_word);
		end
		if (rd_en) begin
			s_d.rd_valid_q    = 1'b1;
			s_d.rd_unmapped_q = 1'b0;
			case (rd_addr)
				anpx_pkg::PARTNER_NP_OFFSET: begin
					s_d.rd_data_q = s_q.np_q;
				end
				anpx_pkg::EXT_STATUS_OFFSET: begin
					s_d.rd_data_q = anpx_pkg::EXT_STATUS_VALUE;
				end
				default: begin
					s_d.rd_data_q     = anpx_pkg::UNMAPPED_READ_VALUE;
					s_d.rd_unmapped_q = 1'b1;
				end
			endcase
		end
	end

	// Both registers are read-only, so the port has no write path at all.
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q.np_q          <= anpx_pkg::PARTNER_NP_RESET;
			s_q.rd_data_q     <= 16'h0000;
			s_q.rd_valid_q    <= 1'b0;
			s_q.rd_unmapped_q <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// The tracker only checks pages in 1000BASE-X, where bit 11 is a real toggle.
	anpx_toggle_track u_trk (
		.clock           (clock),
		.nrst            (nrst),
		.base_load       (base_load),
		.base_toggle     (base_word[anpx_pkg::PAGE_TOGGLE_BIT]),
		.page_load       (page_load & ~sgmii_mode),
		.page_toggle     (page_word[anpx_pkg::PAGE_TOGGLE_BIT]),
		.expected_toggle (expected_toggle),
		.toggle_mismatch (trk_mismatch)
	);

	assign rd_data         = s_q.rd_data_q;
	assign rd_valid        = s_q.rd_valid_q;
	assign rd_unmapped     = s_q.rd_unmapped_q;
	assign toggle_mismatch = trk_mismatch;

endmodule

/* File: anpx_properties.sv */
// Port checker for the next page and extended status register bank.
module anpx_properties (
	input wire logic        clock,
	input wire logic        nrst,
	input wire logic        sgmii_mode,
	input wire logic        base_load,
	input wire logic        page_load,
	input wire logic        rd_en,
	input wire logic        rd_valid,
	input wire logic        rd_unmapped,
	input wire logic        expected_toggle,
	input wire logic        toggle_mismatch,
	input wire logic [4:0]  rd_addr,
	input wire logic [15:0] base_word,
	input wire logic [15:0] page_word,
	input wire logic [15:0] rd_data
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	AST_RDV: assert property (rd_en |=> rd_valid) else $error("read lost");
	AST_NRD: assert property (!rd_en |=> !rd_valid && $stable(rd_data)) else $error("read data moved");
	AST_EXT: assert property (rd_en && rd_addr == 5'h0F |=> rd_data == 16'hA000) else $error("bad status");
	AST_UNM: assert property (rd_en && rd_addr != 5'h08 && rd_addr != 5'h0F
		|=> rd_unmapped && rd_data == 16'h0000) else $error("bad unmapped read");
	AST_FIB: assert property (page_load && !sgmii_mode ##1 rd_en && rd_addr == 5'h08
		|=> rd_data == ($past(page_word, 2) & 16'hBFFF)) else $error("bad fiber page");
	AST_SGM: assert property (page_load && sgmii_mode ##1 rd_en && rd_addr == 5'h08
		|=> rd_data == $past(page_word, 2) && !toggle_mismatch) else $error("bad user page");
	AST_TGB: assert property (base_load |=> expected_toggle != $past(base_word[11])) else $error("bad first toggle");
	AST_TGP: assert property (page_load && !sgmii_mode && !base_load
		|=> toggle_mismatch == ($past(page_word[11]) != $past(expected_toggle))) else $error("bad toggle check");
	cover property (toggle_mismatch);
	cover property (page_load && sgmii_mode);
	cover property (rd_en && rd_addr == 5'h03);
endmodule
////////////////////////////////////////////////////////////////////////
bind anpx_regs anpx_properties chk_i (.*);

/* File: anpx_station.sv */
// Management station model issuing single register reads.
module anpx_station (
	input  wire logic        clock,
	input  wire logic        rd_valid,
	input  wire logic [15:0] rd_data,
	output logic             rd_en,
	output logic [4:0]       rd_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {rd_en, rd_addr} = 6'h00;
	task automatic read(input logic [4:0] a, output logic [15:0] d);
		@(negedge clock);
		{rd_en, rd_addr} = {1'b1, a};
		@(negedge clock);
		{rd_en, rd_addr} = {1'b0, ~a};
		d = rd_valid ? rd_data : 16'hXXXX;
	endtask
endmodule

/* File: test_an_next_page_and_ext_status_regs.sv */
// Bench for the next page and extended status registers.
module test_an_next_page_and_ext_status_regs;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = 1'b0, nrst = 1'b0, sgmii_mode = 1'b0, base_load = 1'b0, page_load = 1'b0;
	logic [15:0] base_word = 16'h0000, page_word = 16'h0000, rd_data, d;
	logic [4:0]  rd_addr;
	logic        rd_en, rd_valid, rd_unmapped, expected_toggle, toggle_mismatch;
	int          miscompares = 0, tests_run = 0;
	always #5 clock = ~clock;
	anpx_regs dut (.*);
	anpx_station st (.*);
	task automatic chk(input logic [15:0] g, e);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %0t %h %h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		st.read(a, d);
		chk(d, e);
	endtask
	task automatic pg(input logic [15:0] w, input logic s, m);
		@(negedge clock);
		{page_load, page_word, sgmii_mode} = {1'b1, w, s};
		@(negedge clock);
		{page_load, page_word} = {1'b0, ~w};
		chk({15'h0000, toggle_mismatch}, {15'h0000, m});
	endtask
	task automatic finish_test();
		$display("run %0d wrong %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#3000;
		miscompares++;
		finish_test();
	end
	initial begin
		repeat (3) @(negedge clock);
		nrst = 1'b1;
		rd(5'h08, 16'h0000);
		rd(5'h0F, 16'hA000);
		rd(5'h03, 16'h0000);
		chk({15'h0000, rd_unmapped}, 16'h0001);
		$display("reset test done");
		base_load = 1'b1;
		@(negedge clock);
		base_load = 1'b0;
		chk({15'h0000, expected_toggle}, 16'h0001);
		pg(16'hFFFF, 1'b0, 1'b0);
		chk({15'h0000, expected_toggle}, 16'h0000);
		rd(5'h08, 16'hBFFF);
		pg(16'h0800, 1'b0, 1'b1);
		pg(16'h4ABC, 1'b1, 1'b0);
		rd(5'h08, 16'h4ABC);
		$display("page test done");
		nrst = 1'b0;
		@(negedge clock);
		nrst = 1'b1;
		rd(5'h08, 16'h0000);
		chk({15'h0000, expected_toggle}, 16'h0000);
		$display("second reset test done");
		finish_test();
	end
endmodule
